//--- common/sfc_defs.svh
// Constants of the serial flash host: timing, byte counts, opcodes.
// Included by bare name; holds definitions only.
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH

// Timing, in ns, and derived cycle counts
`define SFC_CLK_NS 25
`define SFC_SCLK_NS 200
`define SFC_HALF_CYC (((`SFC_SCLK_NS / 2) / `SFC_CLK_NS) < 1 ? 1 : ((`SFC_SCLK_NS / 2) / `SFC_CLK_NS))
`define SFC_CS_GAP_NS 100
`define SFC_CS_GAP_CYC ((`SFC_CS_GAP_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)

// Byte layout
`define SFC_ADDR_BYTES 2'h3
`define SFC_NO_ADDR 2'h0
`define SFC_DMY_0 3'h0
`define SFC_DMY_1 3'h1
`define SFC_DMY_4 3'h4
`define SFC_LEN_REQ 16'h0
`define SFC_LEN_ONE 16'h1
`define SFC_LEN_TWO 16'h2
`define SFC_LEN_ID 16'h3
`define SFC_BYTE_CLKS 4'h8

// Opcodes
`define SFC_O_FAST_ARRAY_READ 8'h0B
`define SFC_O_LOW_POWER_READ 8'h03
`define SFC_O_DUAL_OUTPUT_READ 8'h3B
`define SFC_O_DUAL_IO_READ 8'hBB
`define SFC_O_QUAD_OUTPUT_READ 8'h6B
`define SFC_O_QUAD_IO_READ 8'hEB
`define SFC_O_PAGE_ERASE 8'h81
`define SFC_O_SMALL_REGION_WIPE 8'h20
`define SFC_O_BLOCK_32K_ERASE 8'h52
`define SFC_O_BLOCK_64K_ERASE 8'hD8
`define SFC_O_CHIP_ERASE_A 8'h60
`define SFC_O_CHIP_ERASE_B 8'hC7
`define SFC_O_PAGE_PROGRAM 8'h02
`define SFC_O_DUAL_INPUT_PAGE_PROGRAM 8'hA2
`define SFC_O_QUAD_INPUT_PAGE_PROGRAM 8'h32
`define SFC_O_SUSPEND_A 8'h75
`define SFC_O_SUSPEND_B 8'hB0
`define SFC_O_RESUME_A 8'h7A
`define SFC_O_RESUME_B 8'h30
`define SFC_O_WRITE_ENABLE_CMD 8'h06
`define SFC_O_WRITE_DISABLE_CMD 8'h04
`define SFC_O_VOLATILE_WRITE_ENABLE_CMD 8'h50
`define SFC_O_SECURITY_AREA_ERASE 8'h44
`define SFC_O_SECURITY_AREA_PROGRAM 8'h42
`define SFC_O_SECURITY_AREA_READ 8'h48
`define SFC_O_STATUS_LOW_READ 8'h05
`define SFC_O_STATUS_HIGH_READ 8'h35
`define SFC_O_CONFIG_REG_READ 8'h15
`define SFC_O_BUSY_STATUS_INTERRUPT_ENABLE 8'h25
`define SFC_O_STATUS_REG_WRITE 8'h01
`define SFC_O_CONFIG_REG_WRITE 8'h31
`define SFC_O_RESET_ARM_CMD 8'h66
`define SFC_O_RESET_CMD 8'h99
`define SFC_O_IDENTITY_READ 8'h9F
`define SFC_O_MAKER_DEVICE_CODE_READ 8'h90
`define SFC_O_DUAL_MAKER_DEVICE_CODE_READ 8'h92
`define SFC_O_QUAD_MAKER_DEVICE_CODE_READ 8'h94
`define SFC_O_DEEP_POWER_DOWN 8'hB9
`define SFC_O_POWER_DOWN_RELEASE_ID_READ 8'hAB
`define SFC_O_BURST_LENGTH_SET 8'h77
`define SFC_O_READ_ENHANCED_RELEASE 8'hFF
`define SFC_O_UNIQUE_ID_READ 8'h4B

`endif

//--- common/sfc_pkg.sv
// Types of the serial flash host: states, phases, command descriptors.
// Stands alone; compiled before the host module.
package sfc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOAD = 3'h1,
    ST_LOW = 3'h2,
    ST_HIGH = 3'h3,
    ST_GAP = 3'h4
  } sfc_state_e;

  typedef enum logic [1:0] {
    PH_CMD = 2'h0,
    PH_ADDR = 2'h1,
    PH_DUM = 2'h2,
    PH_DATA = 2'h3
  } sfc_phase_e;

  typedef enum logic [1:0] {
    DIR_NONE = 2'h0,
    DIR_RD = 2'h1,
    DIR_WR = 2'h2
  } sfc_dir_e;

  typedef enum logic [1:0] {
    LN_1 = 2'h0,
    LN_2 = 2'h1,
    LN_4 = 2'h2
  } sfc_lane_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [15:0] len;
  } sfc_req_s;

  typedef struct packed {
    logic ok;
    logic quad;
    logic [1:0] n_addr;
    logic [2:0] n_dum;
    sfc_dir_e dir;
    logic [15:0] fix_len;
    sfc_lane_e addr_ln;
    sfc_lane_e data_ln;
  } sfc_cmd_s;

endpackage

//--- tb/sfc_flash_model.sv
// Behavioural serial flash: opcode capture, write latch, status and data out.
// Assumes mode 0 framing from the host; released lanes show inverted data.
`timescale 1ns/1ps
module sfc_flash_model (
  // Flash pins
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic [3:0] pin_i,
  output logic [3:0] drv_o
);
  // ====
  // Command decode
  logic [7:0] sh = 8'h00;
  logic [7:0] op = 8'h00;
  logic [7:0] st = 8'h00;
  logic write_enable_latch = 1'b0;
  int n = 0;
  initial drv_o = 4'h0;
  always @(negedge cs_b_i) n = 0;
  always @(posedge sclk_i)
  begin
    if (!cs_b_i)
    begin
      sh = {sh[6:0], pin_i[0]};
      n++;
      if (n == 8)
      begin
        op = sh;
        st = (op == 8'h05) ? {6'h00, write_enable_latch, 1'b0} : 8'hA5;
      end
    end
  end
  always @(negedge sclk_i)
  begin
    if (!cs_b_i && n >= 8)
    begin
      drv_o = {4{st[7]}};
      st = {st[6:0], st[7]};
    end
  end
  // Latch changes only when select rises on a byte boundary
  always @(posedge cs_b_i)
  begin
    drv_o = ~drv_o;
    if (n > 0 && n % 8 == 0)
    begin
      if (op == 8'h06) write_enable_latch = 1'b1;
      if (op == 8'h04) write_enable_latch = 1'b0;
    end
  end
endmodule

//--- tb/sfc_host_checker.sv
// Checker of the serial flash host's ports.
// Bound into every sfc_host instance by the statement at the foot.
`timescale 1ns/1ps
module sfc_host_checker #(
  parameter logic [7:0] HALF_CYC = 8'h4,
  parameter logic [7:0] CS_GAP_CYC = 8'h4
) (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  input wire sfc_pkg::sfc_req_s req_i,
  input wire logic req_ready_o,
  input wire logic quad_enable_bit_i,
  input wire logic rx_valid_o,
  input wire logic [7:0] rx_data_o,
  input wire logic rx_ready_i,
  input wire logic done_o,
  input wire logic refused_o,
  input wire logic sclk_o,
  input wire logic cs_b_o,
  input wire logic [3:0] io_o
);
  // ====
  // Bit count within a byte, last completed opcode
  logic take;
  logic sclk_q;
  logic [2:0] bits_reg, bits_next;
  logic [7:0] cur_reg, cur_next, last_reg, last_next;
  assign take = req_valid_i && req_ready_o;
  always_comb
  begin
    bits_next = cs_b_o ? 3'h0 : bits_reg + {2'h0, sclk_o & ~sclk_q};
    cur_next = take ? req_i.opcode : cur_reg;
    last_next = done_o ? cur_reg : last_reg;
  end
  always_ff @(posedge clk_i)
  begin
    sclk_q <= rst_b_i & sclk_o;
    bits_reg <= rst_b_i ? bits_next : 3'h0;
    cur_reg <= rst_b_i ? cur_next : 8'h00;
    last_reg <= rst_b_i ? last_next : 8'h00;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_refuse_quiet: assert property (refused_o |-> cs_b_o && !sclk_o)
    else $error("refusal moved select or clock");
  a_unknown_op: assert property (take && req_i.opcode == 8'h5A |=> refused_o)
    else $error("unknown opcode not refused");
  a_quad_gate: assert property (take && !quad_enable_bit_i &&
    req_i.opcode inside {8'h6B, 8'hEB, 8'h32, 8'h94} |=> refused_o)
    else $error("quad opcode passed without enable");
  a_quad_pass: assert property (take && quad_enable_bit_i && req_i.opcode == 8'h6B
    |=> !cs_b_o && !refused_o)
    else $error("enabled quad read not started");
  a_reset_arm: assert property (take && req_i.opcode == 8'h99 && last_reg != 8'h66
    |=> refused_o)
    else $error("reset accepted without arm");
  a_byte_bound: assert property ($rose(cs_b_o) |-> done_o && (bits_reg == 3'h0 ||
    cur_reg inside {8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hA2, 8'h32, 8'h92, 8'h94}))
    else $error("select rose off a byte boundary");
  a_clock_idle: assert property (cs_b_o |-> !sclk_o)
    else $error("clock active outside frame");
  a_data_steady: assert property (sclk_o |-> $stable(io_o))
    else $error("data changed while clock high");
  a_read_hold: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("read byte lost during stall");
  a_latch_frame: assert property (take && req_i.opcode == 8'h06
    |=> !cs_b_o ##[8:300] $rose(cs_b_o) && done_o)
    else $error("write enable frame not closed");
endmodule
bind sfc_host sfc_host_checker #(.HALF_CYC(HALF_CYC), .CS_GAP_CYC(CS_GAP_CYC)) u_chk (.*);

//--- tb/test_sfc_host.sv
// Bench for the serial flash host: command table, refusals, latch, read stall.
// Assumes the flash model and checker in tb/, package and defines in common/.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module test_sfc_host;
  // ====
  // Signals and command table {opcode, length, clock count}
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req_valid_i = 1'b0;
  sfc_pkg::sfc_req_s req_i = '0;
  logic quad_enable_bit_i = 1'b0;
  logic tx_valid_i = 1'b0;
  logic [7:0] tx_data_i = 8'h5A;
  logic rx_ready_i = 1'b1;
  logic req_ready_o, tx_ready_o, rx_valid_o, done_o, refused_o, busy_o, sclk_o, cs_b_o;
  logic [7:0] rx_data_o;
  logic [3:0] io_o, io_oe_o, io_i, flash_io;
  logic [7:0] rxq[$];
  int error_cnt = 0;
  int checked = 0;
  int edges = 0;
  int tx_cnt = 0;
  logic [23:0] tbl[33] = '{24'h0B0130, 24'h030230, 24'h3B012C,
    24'hBB011C, 24'h6B012A, 24'hEB0112,
    24'h200020, 24'h810020, 24'h520020, 24'hD80020, 24'h600008, 24'hC70008,
    24'h020128, 24'hA20124, 24'h320122, 24'h500008,
    24'h440020, 24'h420128, 24'h480130, 24'h150010, 24'h350010,
    24'h250010, 24'h010018, 24'h310010, 24'h9F0020,
    24'h900128, 24'hB90008, 24'hAB0028, 24'hFF0008,
    24'h92012C, 24'h94012A, 24'h750008, 24'h7A0008};
  assign io_i = (io_oe_o & io_o) | (~io_oe_o & flash_io);
  always #12.5 clk_i = ~clk_i;
  always @(posedge sclk_o) if (cs_b_o === 1'b0) edges++;
  always @(posedge clk_i) if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) tx_cnt++;
  always @(posedge clk_i) if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) rxq.push_back(rx_data_o);
  sfc_host #(.HALF_CYC(8'h2), .CS_GAP_CYC(8'h4)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .quad_enable_bit_i(quad_enable_bit_i), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
    .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
    .rx_ready_i(rx_ready_i), .done_o(done_o), .refused_o(refused_o), .busy_o(busy_o),
    .sclk_o(sclk_o), .cs_b_o(cs_b_o), .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_i));
  sfc_flash_model u_flash (.sclk_i(sclk_o), .cs_b_i(cs_b_o), .pin_i(io_i), .drv_o(flash_io));
  task automatic final_report;
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic timeout;
    error_cnt++;
    final_report();
  endtask
  task automatic issue(input logic [7:0] op, input logic [15:0] len);
    int n;
    n = 0;
    req_i <= {op, 24'h012345, len};
    req_valid_i <= 1'b1;
    do begin @(posedge clk_i); n++; end while (req_ready_o !== 1'b1 && n < 99);
    req_valid_i <= 1'b0;
    edges = 0;
    if (n >= 99) timeout();
  endtask
  task automatic finish(input logic ok, input int clks);
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (done_o !== 1'b1 && refused_o !== 1'b1 && n < 9999);
    if (n >= 9999) timeout();
    `CHK(done_o, ok)
    `CHK(edges, clks)
    repeat (2) @(posedge clk_i);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] len, input logic ok, input int clks);
    issue(op, len);
    finish(ok, clks);
  endtask
  task automatic t_latch;
    cmd(8'h06, 16'h0000, 1'b1, 8);
    cmd(8'h05, 16'h0000, 1'b1, 16);
    `CHK(rxq[$], 8'h02)
    cmd(8'h04, 16'h0000, 1'b1, 8);
    cmd(8'h05, 16'h0000, 1'b1, 16);
    `CHK(rxq[$], 8'h00)
  endtask
  task automatic t_refuse;
    cmd(8'h6B, 16'h0001, 1'b0, 0);
    cmd(8'h5A, 16'h0000, 1'b0, 0);
    cmd(8'h99, 16'h0000, 1'b0, 0);
    cmd(8'h66, 16'h0000, 1'b1, 8);
    cmd(8'h99, 16'h0000, 1'b1, 8);
    cmd(8'h99, 16'h0000, 1'b0, 0);
  endtask
  task automatic t_table;
    quad_enable_bit_i <= 1'b1;
    tx_valid_i <= 1'b1;
    foreach (tbl[i])
      cmd(tbl[i][23:16], {8'h00, tbl[i][15:8]}, 1'b1, int'(tbl[i][7:0]));
    cmd(8'h3B, 16'h0001, 1'b1, 44);
    `CHK(rxq[$], 8'hCC)
    cmd(8'hEB, 16'h0001, 1'b1, 18);
    `CHK(rxq[$], 8'hF0)
    cmd(8'h02, 16'h0001, 1'b1, 40);
    `CHK(u_flash.sh, 8'h5A)
    `CHK(tx_cnt, 8)
    quad_enable_bit_i <= 1'b0;
  endtask
  task automatic t_stall;
    rxq.delete();
    rx_ready_i <= 1'b0;
    issue(8'h03, 16'h0004);
    repeat (300) @(posedge clk_i);
    `CHK(rx_valid_o, 1'b1)
    `CHK(busy_o, 1'b1)
    rx_ready_i <= 1'b1;
    finish(1'b1, 64);
    `CHK(rxq.size(), 4)
    `CHK(rxq[3], 8'hA5)
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_latch();
    t_refuse();
    t_table();
    t_stall();
    final_report();
  end
endmodule

//--- verilog/sfc_host.sv
// Host controller that drives a serial multi-I/O flash over its pins.
// Assumes clk_i at 40 MHz; flash pins are asynchronous to it.
//
// Summary of operation
// - Fast array read: three address, one dummy, data streams until select rises.
// - Low-power read: three address, no dummy, then data bytes.
// - Dual-output read: single-lane address and dummy, data on two lanes.
// - Dual-I/O read: address and dummy on two lanes, data on two lanes.
// - Quad-output read: single-lane address and dummy, data on four lanes.
// - Quad-I/O read: address and dummy on four lanes, data on four lanes.
// - Sector and page erase: three address bytes, nothing else.
// - Block erases take three address bytes; chip erase takes none.
// - Page programs, single, dual, quad: three address bytes, then data.
// - Security erase, program take address; security read adds a dummy.
// - Busy status interrupt enable: one dummy byte, no data.
// - Status write: two data bytes, no address, no dummy.
// - Config write: exactly one data byte.
// - Maker/device code reads take address; dual and quad add a dummy.
// - Power-down release: three address bytes, one identity byte back.
// - Select rises only on a byte boundary.
// - Bits sampled on rising clock, shifted on falling; mode 0 used.
`timescale 1ns/1ps
`include "sfc_defs.svh"

module sfc_host #(
  parameter logic [7:0] HALF_CYC = 8'(`SFC_HALF_CYC),
  parameter logic [7:0] CS_GAP_CYC = 8'(`SFC_CS_GAP_CYC)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Command request
  input wire logic req_valid_i,
  input wire sfc_pkg::sfc_req_s req_i,
  output logic req_ready_o,
  input wire logic quad_enable_bit_i,
  // Write data stream
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  // Read data stream
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_ready_i,
  // Status
  output logic done_o,
  output logic refused_o,
  output logic busy_o,
  // Flash pins
  output logic sclk_o,
  output logic cs_b_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  input wire logic [3:0] io_i
);

  // ==========================================================
  // Functions
  function automatic sfc_pkg::sfc_cmd_s mk(input logic [1:0] na, input logic [2:0] nd,
      input sfc_pkg::sfc_dir_e dir, input logic [15:0] fl,
      input sfc_pkg::sfc_lane_e aln, input sfc_pkg::sfc_lane_e dln);
    sfc_pkg::sfc_cmd_s c;
    c.ok = 1'b1;
    c.quad = (aln == sfc_pkg::LN_4) || (dln == sfc_pkg::LN_4);
    c.n_addr = na;
    c.n_dum = nd;
    c.dir = dir;
    c.fix_len = fl;
    c.addr_ln = aln;
    c.data_ln = dln;
    return c;
  endfunction

  function automatic sfc_pkg::sfc_cmd_s decode(input logic [7:0] op);
    sfc_pkg::sfc_cmd_s d;
    d = '0;
    unique case (op)
      `SFC_O_FAST_ARRAY_READ, `SFC_O_SECURITY_AREA_READ:
        d = mk(`SFC_ADDR_BYTES, `SFC_DMY_1, sfc_pkg::DIR_RD, `SFC_LEN_REQ,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      `SFC_O_LOW_POWER_READ, `SFC_O_MAKER_DEVICE_CODE_READ:
        d = mk(`SFC_ADDR_BYTES, `SFC_DMY_0, sfc_pkg::DIR_RD, `SFC_LEN_REQ,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      `SFC_O_DUAL_OUTPUT_READ, `SFC_O_DUAL_MAKER_DEVICE_CODE_READ:
        d = mk(`SFC_ADDR_BYTES, `SFC_DMY_1, sfc_pkg::DIR_RD, `SFC_LEN_REQ,
               sfc_pkg::LN_1, sfc_pkg::LN_2);
      `SFC_O_DUAL_IO_READ:
        d = mk(`SFC_ADDR_BYTES, `SFC_DMY_1, sfc_pkg::DIR_RD, `SFC_LEN_REQ,
               sfc_pkg::LN_2, sfc_pkg::LN_2);
      `SFC_O_QUAD_OUTPUT_READ, `SFC_O_QUAD_MAKER_DEVICE_CODE_READ:
        d = mk(`SFC_ADDR_BYTES, `SFC_DMY_1, sfc_pkg::DIR_RD, `SFC_LEN_REQ,
               sfc_pkg::LN_1, sfc_pkg::LN_4);
      `SFC_O_QUAD_IO_READ:
        d = mk(`SFC_ADDR_BYTES, `SFC_DMY_1, sfc_pkg::DIR_RD, `SFC_LEN_REQ,
               sfc_pkg::LN_4, sfc_pkg::LN_4);
      `SFC_O_PAGE_ERASE, `SFC_O_SMALL_REGION_WIPE, `SFC_O_BLOCK_32K_ERASE,
      `SFC_O_BLOCK_64K_ERASE, `SFC_O_SECURITY_AREA_ERASE:
        d = mk(`SFC_ADDR_BYTES, `SFC_DMY_0, sfc_pkg::DIR_NONE, `SFC_LEN_REQ,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      `SFC_O_PAGE_PROGRAM, `SFC_O_SECURITY_AREA_PROGRAM:
        d = mk(`SFC_ADDR_BYTES, `SFC_DMY_0, sfc_pkg::DIR_WR, `SFC_LEN_REQ,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      `SFC_O_DUAL_INPUT_PAGE_PROGRAM:
        d = mk(`SFC_ADDR_BYTES, `SFC_DMY_0, sfc_pkg::DIR_WR, `SFC_LEN_REQ,
               sfc_pkg::LN_1, sfc_pkg::LN_2);
      `SFC_O_QUAD_INPUT_PAGE_PROGRAM:
        d = mk(`SFC_ADDR_BYTES, `SFC_DMY_0, sfc_pkg::DIR_WR, `SFC_LEN_REQ,
               sfc_pkg::LN_1, sfc_pkg::LN_4);
      `SFC_O_CHIP_ERASE_A, `SFC_O_CHIP_ERASE_B, `SFC_O_WRITE_ENABLE_CMD,
      `SFC_O_WRITE_DISABLE_CMD, `SFC_O_VOLATILE_WRITE_ENABLE_CMD,
      `SFC_O_DEEP_POWER_DOWN, `SFC_O_READ_ENHANCED_RELEASE,
      `SFC_O_SUSPEND_A, `SFC_O_SUSPEND_B, `SFC_O_RESUME_A, `SFC_O_RESUME_B,
      `SFC_O_RESET_ARM_CMD, `SFC_O_RESET_CMD,
      `SFC_O_BURST_LENGTH_SET:
        d = mk(`SFC_NO_ADDR, `SFC_DMY_0, sfc_pkg::DIR_NONE, `SFC_LEN_REQ,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      `SFC_O_STATUS_LOW_READ, `SFC_O_STATUS_HIGH_READ, `SFC_O_CONFIG_REG_READ:
        d = mk(`SFC_NO_ADDR, `SFC_DMY_0, sfc_pkg::DIR_RD, `SFC_LEN_ONE,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      `SFC_O_BUSY_STATUS_INTERRUPT_ENABLE:
        d = mk(`SFC_NO_ADDR, `SFC_DMY_1, sfc_pkg::DIR_NONE, `SFC_LEN_REQ,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      `SFC_O_STATUS_REG_WRITE:
        d = mk(`SFC_NO_ADDR, `SFC_DMY_0, sfc_pkg::DIR_WR, `SFC_LEN_TWO,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      `SFC_O_CONFIG_REG_WRITE:
        d = mk(`SFC_NO_ADDR, `SFC_DMY_0, sfc_pkg::DIR_WR, `SFC_LEN_ONE,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      `SFC_O_IDENTITY_READ:
        d = mk(`SFC_NO_ADDR, `SFC_DMY_0, sfc_pkg::DIR_RD, `SFC_LEN_ID,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      `SFC_O_POWER_DOWN_RELEASE_ID_READ:
        d = mk(`SFC_ADDR_BYTES, `SFC_DMY_0, sfc_pkg::DIR_RD, `SFC_LEN_ONE,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      `SFC_O_UNIQUE_ID_READ:
        d = mk(`SFC_NO_ADDR, `SFC_DMY_4, sfc_pkg::DIR_RD, `SFC_LEN_REQ,
               sfc_pkg::LN_1, sfc_pkg::LN_1);
      default:
        d = '0;
    endcase
    return d;
  endfunction

  // ==========================================================
  // State
  sfc_pkg::sfc_state_e state_reg, state_next;
  sfc_pkg::sfc_phase_e phase_reg, phase_next;
  sfc_pkg::sfc_cmd_s cmd_reg, cmd_next, info;
  sfc_pkg::sfc_lane_e lw_reg, lw_next;
  logic [7:0] op_reg, op_next;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] len_reg, len_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] div_reg, div_next;
  logic [7:0] sr_reg, sr_next;
  logic rd_reg, rd_next;
  logic armed_reg, armed_next;
  logic sclk_reg, sclk_next;
  logic cs_b_reg, cs_b_next;
  logic [3:0] io_reg, io_next;
  logic [3:0] oe_reg, oe_next;
  logic req_ready_reg, req_ready_next;
  logic tx_ready_reg, tx_ready_next;
  logic done_reg, done_next;
  logic refused_reg, refused_next;
  logic busy_reg, busy_next;
  logic [3:0] io_s1_reg, io_s2_reg;
  logic [1:0] b_vld_reg, b_vld_next;
  logic [7:0] b_dat_reg [2];
  logic [7:0] b_dat_next [2];
  logic push;
  logic go;
  logic [7:0] byte_val;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg;
    cmd_next = cmd_reg;
    lw_next = lw_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    len_next = len_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    div_next = div_reg;
    sr_next = sr_reg;
    rd_next = rd_reg;
    armed_next = armed_reg;
    sclk_next = sclk_reg;
    cs_b_next = cs_b_reg;
    oe_next = oe_reg;
    busy_next = busy_reg;
    req_ready_next = 1'b0;
    tx_ready_next = 1'b0;
    done_next = 1'b0;
    refused_next = 1'b0;
    push = 1'b0;
    go = 1'b0;
    byte_val = 8'h00;
    info = decode(req_i.opcode);
    unique case (state_reg)
      sfc_pkg::ST_IDLE:
      begin
        req_ready_next = 1'b1;
        if (req_valid_i && req_ready_reg)
        begin
          req_ready_next = 1'b0;
          if (!info.ok || (info.quad && !quad_enable_bit_i)
              || (req_i.opcode == `SFC_O_RESET_CMD && !armed_reg))
            refused_next = 1'b1;
          else
          begin
            cmd_next = info;
            op_next = req_i.opcode;
            addr_next = req_i.addr;
            len_next = (info.fix_len != `SFC_LEN_REQ) ? info.fix_len : req_i.len;
            phase_next = sfc_pkg::PH_CMD;
            cnt_next = `SFC_LEN_ONE;
            cs_b_next = 1'b0;
            busy_next = 1'b1;
            state_next = sfc_pkg::ST_LOAD;
          end
        end
      end
      sfc_pkg::ST_LOAD:
      begin
        if (cnt_reg == 16'h0000)
        begin
          unique case (phase_reg)
            sfc_pkg::PH_CMD:
            begin
              phase_next = sfc_pkg::PH_ADDR;
              cnt_next = 16'(cmd_reg.n_addr);
            end
            sfc_pkg::PH_ADDR:
            begin
              phase_next = sfc_pkg::PH_DUM;
              cnt_next = 16'(cmd_reg.n_dum);
            end
            sfc_pkg::PH_DUM:
            begin
              phase_next = sfc_pkg::PH_DATA;
              cnt_next = (cmd_reg.dir == sfc_pkg::DIR_NONE) ? 16'h0000 : len_reg;
            end
            sfc_pkg::PH_DATA:
            begin
              cs_b_next = 1'b1;
              oe_next = 4'h0;
              done_next = 1'b1;
              busy_next = 1'b0;
              armed_next = (op_reg == `SFC_O_RESET_ARM_CMD);
              div_next = CS_GAP_CYC;
              state_next = sfc_pkg::ST_GAP;
            end
          endcase
        end
        else
        begin
          rd_next = 1'b0;
          unique case (phase_reg)
            sfc_pkg::PH_CMD:
            begin
              byte_val = op_reg;
              lw_next = sfc_pkg::LN_1;
              go = 1'b1;
            end
            sfc_pkg::PH_ADDR:
            begin
              byte_val = addr_reg[23:16];
              addr_next = {addr_reg[15:0], 8'h00};
              lw_next = cmd_reg.addr_ln;
              go = 1'b1;
            end
            sfc_pkg::PH_DUM:
            begin
              lw_next = cmd_reg.addr_ln;
              go = 1'b1;
            end
            sfc_pkg::PH_DATA:
            begin
              lw_next = cmd_reg.data_ln;
              if (cmd_reg.dir == sfc_pkg::DIR_WR)
              begin
                tx_ready_next = !(tx_valid_i && tx_ready_reg);
                go = tx_valid_i && tx_ready_reg;
                byte_val = tx_data_i;
              end
              else
              begin
                rd_next = 1'b1;
                go = !b_vld_reg[1];
              end
            end
          endcase
          if (go)
          begin
            sr_next = byte_val;
            bit_next = `SFC_BYTE_CLKS >> lw_next;
            cnt_next = cnt_reg - 16'h0001;
            oe_next = oe_for(lw_next, rd_next);
            div_next = HALF_CYC;
            state_next = sfc_pkg::ST_LOW;
          end
        end
      end
      sfc_pkg::ST_LOW:
      begin
        if (div_reg <= 8'h01)
        begin
          sclk_next = 1'b1;
          div_next = HALF_CYC;
          state_next = sfc_pkg::ST_HIGH;
        end
        else
          div_next = div_reg - 8'h01;
      end
      sfc_pkg::ST_HIGH:
      begin
        if (div_reg <= 8'h01)
        begin
          sclk_next = 1'b0;
          sr_next = shift_in(sr_reg, io_s2_reg, lw_reg);
          bit_next = bit_reg - 4'h1;
          div_next = HALF_CYC;
          if (bit_reg == 4'h1)
          begin
            push = rd_reg;
            state_next = sfc_pkg::ST_LOAD;
          end
          else
            state_next = sfc_pkg::ST_LOW;
        end
        else
          div_next = div_reg - 8'h01;
      end
      sfc_pkg::ST_GAP:
      begin
        if (div_reg <= 8'h01)
        begin
          req_ready_next = 1'b1;
          state_next = sfc_pkg::ST_IDLE;
        end
        else
          div_next = div_reg - 8'h01;
      end
      default:
        state_next = sfc_pkg::ST_IDLE;
    endcase
    io_next = cs_b_next ? 4'h0 : lanes_out(sr_next, lw_next);
  end

  // ==========================================================
  // Two-entry read buffer
  always_comb
  begin
    b_vld_next = b_vld_reg;
    b_dat_next = b_dat_reg;
    if (rx_ready_i && b_vld_reg[0])
    begin
      b_vld_next = {1'b0, b_vld_reg[1]};
      b_dat_next[0] = b_dat_reg[1];
    end
    if (push)
    begin
      if (b_vld_next[0])
      begin
        b_vld_next[1] = 1'b1;
        b_dat_next[1] = sr_next;
      end
      else
      begin
        b_vld_next[0] = 1'b1;
        b_dat_next[0] = sr_next;
      end
    end
  end

  // ==========================================================
  // Lane helpers
  function automatic logic [3:0] lanes_out(input logic [7:0] s, input sfc_pkg::sfc_lane_e l);
    unique case (l)
      sfc_pkg::LN_2: lanes_out = {2'b11, s[7:6]};
      sfc_pkg::LN_4: lanes_out = s[7:4];
      default: lanes_out = {3'b110, s[7]};
    endcase
  endfunction

  function automatic logic [3:0] oe_for(input sfc_pkg::sfc_lane_e l, input logic rd);
    unique case (l)
      sfc_pkg::LN_2: oe_for = rd ? 4'hC : 4'hF;
      sfc_pkg::LN_4: oe_for = rd ? 4'h0 : 4'hF;
      default: oe_for = 4'hD;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] p,
      input sfc_pkg::sfc_lane_e l);
    unique case (l)
      sfc_pkg::LN_2: shift_in = {s[5:0], p[1:0]};
      sfc_pkg::LN_4: shift_in = {s[3:0], p};
      default: shift_in = {s[6:0], p[1]};
    endcase
  endfunction

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i)
  begin
    io_s1_reg <= io_i;
    io_s2_reg <= io_s1_reg;
    if (!rst_b_i)
    begin
      state_reg <= sfc_pkg::ST_IDLE;
      phase_reg <= sfc_pkg::PH_CMD;
      cmd_reg <= '0;
      lw_reg <= sfc_pkg::LN_1;
      op_reg <= 8'h00;
      addr_reg <= 24'h000000;
      len_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      div_reg <= 8'h00;
      sr_reg <= 8'h00;
      rd_reg <= 1'b0;
      armed_reg <= 1'b0;
      sclk_reg <= 1'b0;
      cs_b_reg <= 1'b1;
      io_reg <= 4'h0;
      oe_reg <= 4'h0;
      req_ready_reg <= 1'b0;
      tx_ready_reg <= 1'b0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      busy_reg <= 1'b0;
      b_vld_reg <= 2'b00;
      b_dat_reg[0] <= 8'h00;
      b_dat_reg[1] <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cmd_reg <= cmd_next;
      lw_reg <= lw_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      len_reg <= len_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      div_reg <= div_next;
      sr_reg <= sr_next;
      rd_reg <= rd_next;
      armed_reg <= armed_next;
      sclk_reg <= sclk_next;
      cs_b_reg <= cs_b_next;
      io_reg <= io_next;
      oe_reg <= oe_next;
      req_ready_reg <= req_ready_next;
      tx_ready_reg <= tx_ready_next;
      done_reg <= done_next;
      refused_reg <= refused_next;
      busy_reg <= busy_next;
      b_vld_reg <= b_vld_next;
      b_dat_reg <= b_dat_next;
    end
  end

  assign req_ready_o = req_ready_reg;
  assign tx_ready_o = tx_ready_reg;
  assign rx_valid_o = b_vld_reg[0];
  assign rx_data_o = b_dat_reg[0];
  assign done_o = done_reg;
  assign refused_o = refused_reg;
  assign busy_o = busy_reg;
  assign sclk_o = sclk_reg;
  assign cs_b_o = cs_b_reg;
  assign io_o = io_reg;
  assign io_oe_o = oe_reg;

endmodule
